// ==== hw/gpc_pkg.sv ====
package gpc_pkg;

   localparam int PINS = 8;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   localparam logic [ADDR_W-1:0] OFS_DATA_A = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_DATA_B = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_DIR_A = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_DIR_B = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_OPT_A = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_OPT_B = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_IRQ_OPT = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h1c;
   localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR = 8'h20;
   localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 8'h24;

   localparam logic [PINS-1:0] RST_PORT = 8'h00;
   localparam logic [7:0] RST_IRQ_OPT = 8'h00;
   localparam logic [7:0] IRQ_OPT_MASK = 8'h70;
   localparam int BIT_LEVEL_EDGE_A = 6;
   localparam int BIT_EDGE_B = 5;
   localparam int BIT_GLOBAL_EN = 4;

   localparam int IRQ_W = 2;
   localparam int IRQ_PORT_A = 0;
   localparam int IRQ_PORT_B = 1;
   localparam logic [IRQ_W-1:0] RST_IRQ = 2'h0;

   localparam logic [PINS-1:0] ANALOG_MASK_A = 8'h00;
   localparam logic [PINS-1:0] ANALOG_MASK_B = 8'he8;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {TRIG_FALL, TRIG_RISE, TRIG_LOW} gpc_trig_t;

   // Pins in input mode with option set and data clear feed the interrupt system
   function automatic logic [PINS-1:0] gpc_irq_cfg(input logic [PINS-1:0] dir,
                                                  input logic [PINS-1:0] opt,
                                                  input logic [PINS-1:0] dat);
      gpc_irq_cfg = ~dir & opt & ~dat;
   endfunction : gpc_irq_cfg

endpackage : gpc_pkg

// ==== hw/gpc_port.sv ====
`timescale 1ns/10ps
module gpc_port
   import gpc_pkg::*;
#(
   parameter int PIN_N = PINS,
   parameter logic [PIN_N-1:0] ANALOG_MASK = '0
) (
   input wire logic core_clk_i, // System clock
   input wire logic rst_i, // Synchronous reset
   input wire logic [PIN_N-1:0] dir_i, // Direction bits
   input wire logic [PIN_N-1:0] opt_i, // Option bits
   input wire logic [PIN_N-1:0] dat_i, // Data latch bits
   input wire logic [PIN_N-1:0] pad_i, // Pin levels from outside
   output logic [PIN_N-1:0] pad_o, // Pin output value
   output logic [PIN_N-1:0] pad_oe_o, // Pin output enable
   output logic [PIN_N-1:0] pull_en_o, // Pull-up enable
   output logic [PIN_N-1:0] analog_en_o, // Analog switch to converter
   output logic [PIN_N-1:0] level_o // Synchronised pin level
);

   logic [PIN_N-1:0] sync_meta;

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         sync_meta <= '1;
         level_o <= '1;
      end else begin
         sync_meta <= pad_i;
         level_o <= sync_meta;
      end
   end

   // Drive comes only from the three bits; peripherals never take a pin on their own
   for (genvar i = 0; i < PIN_N; i++) begin : g_pin
      always_ff @(posedge core_clk_i) begin
         if (rst_i) begin
            pad_o[i] <= 1'b0;
            pad_oe_o[i] <= 1'b0;
            // Cleared registers mean input with pull-up, so the pull is on from reset
            pull_en_o[i] <= 1'b1;
            analog_en_o[i] <= 1'b0;
         end else begin
            // Open drain only ever pulls low; a one releases the pin
            pad_o[i] <= dat_i[i] & opt_i[i];
            pad_oe_o[i] <= dir_i[i] & (opt_i[i] | ~dat_i[i]);
            pull_en_o[i] <= ~dir_i[i] & ~dat_i[i];
            analog_en_o[i] <= ~dir_i[i] & opt_i[i] & dat_i[i] & ANALOG_MASK[i];
         end
      end
   end

   logic [PIN_N-1:0] push_pull;
   logic [PIN_N-1:0] open_drain;
   assign push_pull = dir_i & opt_i;
   assign open_drain = dir_i & ~opt_i;

   a_push_pull_drive: assert property (@(posedge core_clk_i) disable iff (rst_i)
      ((pad_oe_o & $past(push_pull)) == $past(push_pull))
      && ((pad_o & $past(push_pull)) == ($past(dat_i) & $past(push_pull))))
      else $error("push-pull pin not driving its latch value");
   a_open_drain_low: assert property (@(posedge core_clk_i) disable iff (rst_i)
      ((pad_oe_o & pad_o & $past(open_drain)) == '0)
      && ((pad_oe_o & $past(open_drain)) == ($past(~dat_i) & $past(open_drain))))
      else $error("open-drain pin drove high or failed to pull low");
   a_input_modes: assert property (@(posedge core_clk_i) disable iff (rst_i)
      ((pull_en_o & analog_en_o) == '0) && ((pull_en_o & pad_oe_o) == '0)
      && ((analog_en_o & pad_oe_o) == '0))
      else $error("input modes overlap with each other or with drive");
   a_analog_only: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (analog_en_o & ~ANALOG_MASK) == '0)
      else $error("analog switch closed on a pin without converter input");

endmodule : gpc_port

// ==== hw/gpc_trig.sv ====
`timescale 1ns/10ps
module gpc_trig
   import gpc_pkg::*;
#(
   parameter int PIN_N = PINS
) (
   input wire logic core_clk_i, // System clock
   input wire logic rst_i, // Synchronous reset
   input wire logic [PIN_N-1:0] level_i, // Synchronised pin levels
   input wire logic [PIN_N-1:0] cfg_i, // Pins set up for interrupt
   input wire gpc_trig_t mode_i, // Trigger condition of the port
   output logic req_o // Combined request, one per qualifying cycle
);

   logic [PIN_N-1:0] prev;
   logic [PIN_N-1:0] hit;

   always_comb begin
      unique case (mode_i)
         TRIG_FALL: hit = prev & ~level_i;
         TRIG_RISE: hit = ~prev & level_i;
         TRIG_LOW: hit = ~level_i;
         default: hit = '0;
      endcase
   end

   // Idle level is high, so reset to high avoids a false edge on release
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         prev <= '1;
         req_o <= 1'b0;
      end else begin
         prev <= level_i;
         req_o <= |(hit & cfg_i);
      end
   end

   a_fall_edge: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (mode_i == TRIG_FALL && |(cfg_i & prev & ~level_i)) |=> req_o)
      else $error("falling edge on an interrupt pin gave no request");
   a_rise_edge: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (mode_i == TRIG_RISE && (cfg_i & ~prev & level_i) == '0
       && (mode_i != TRIG_LOW)) |=> !req_o)
      else $error("request without a rising edge in rising mode");

endmodule : gpc_trig

// ==== hw/gpc_top.sv ====
// Local design decisions: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
// Overview of operation
// - Each port has eight pins; bit x of every port register controls pin x.
// - Per port: direction, data and option registers, every pin set independently.
// - Reset clears all port registers: input, pull-up, no interrupt.
// - Data read of an input pin returns the synchronised pin level.
// - Input, option 0, data 0: pull-up on, no interrupt.
// - Input, option 0, data 1: no pull-up, no interrupt.
// - Input, option 1, data 0: pull-up on, pin feeds interrupt logic.
// - Input, option 1, data 1: capable pin switched to converter input.
// - Output pin drives the data latch; reads return the latch.
// - Output option 0 is open-drain, option 1 push-pull, both driven by the data latch.
// - Data 0 drives low; data 1 drives high or floats in open-drain.
// - Software picks trigger per port: falling or low level on A, falling or rising on B.
// - Peripheral use of a pin happens only through the three bits.
// - Interrupt requests pass only while the global enable is set.
// - Data writes update the latch even for input pins.
// - Port A select 0 means falling edge, 1 means low level.
// - Port B select 0 means falling edge, 1 means rising edge.
module gpc_top
   import gpc_pkg::*;
#(
   parameter logic [PINS-1:0] ANALOG_A = ANALOG_MASK_A,
   parameter logic [PINS-1:0] ANALOG_B = ANALOG_MASK_B
) (
   input wire logic core_clk_i, // System clock, 50 MHz
   input wire logic rst_i, // Synchronous reset, active high
   input wire logic [ADDR_W-1:0] s_axi_awaddr_i, // Write address
   input wire logic s_axi_awvalid_i, // Write address valid
   output logic s_axi_awready_o, // Write address ready
   input wire logic [DATA_W-1:0] s_axi_wdata_i, // Write data
   input wire logic [DATA_W/8-1:0] s_axi_wstrb_i, // Write byte strobes
   input wire logic s_axi_wvalid_i, // Write data valid
   output logic s_axi_wready_o, // Write data ready
   output logic [1:0] s_axi_bresp_o, // Write response
   output logic s_axi_bvalid_o, // Write response valid
   input wire logic s_axi_bready_i, // Write response ready
   input wire logic [ADDR_W-1:0] s_axi_araddr_i, // Read address
   input wire logic s_axi_arvalid_i, // Read address valid
   output logic s_axi_arready_o, // Read address ready
   output logic [DATA_W-1:0] s_axi_rdata_o, // Read data
   output logic [1:0] s_axi_rresp_o, // Read response
   output logic s_axi_rvalid_o, // Read data valid
   input wire logic s_axi_rready_i, // Read data ready
   input wire logic [PINS-1:0] porta_pad_i, // Port A pin levels
   output logic [PINS-1:0] porta_pad_o, // Port A pin output value
   output logic [PINS-1:0] porta_pad_oe_o, // Port A output enable
   output logic [PINS-1:0] porta_pull_en_o, // Port A pull-up enable
   output logic [PINS-1:0] porta_analog_en_o, // Port A analog switch
   input wire logic [PINS-1:0] portb_pad_i, // Port B pin levels
   output logic [PINS-1:0] portb_pad_o, // Port B pin output value
   output logic [PINS-1:0] portb_pad_oe_o, // Port B output enable
   output logic [PINS-1:0] portb_pull_en_o, // Port B pull-up enable
   output logic [PINS-1:0] portb_analog_en_o, // Port B analog switch
   output logic irq_o // Interrupt, high while an enabled status bit is set
);

   // Register state
   logic [PINS-1:0] pin_data_bits_a;
   logic [PINS-1:0] pin_data_bits_b;
   logic [PINS-1:0] dir_a;
   logic [PINS-1:0] dir_b;
   logic [PINS-1:0] opt_a;
   logic [PINS-1:0] opt_b;
   logic [7:0] irq_opt;
   logic [IRQ_W-1:0] irq_status;
   logic [IRQ_W-1:0] irq_enable;

   // Bus state
   logic aw_held;
   logic w_held;
   logic [ADDR_W-1:0] aw_addr;
   logic [7:0] w_byte;
   logic w_lane0;
   logic wr_fire;

   // Port-side signals
   logic [PINS-1:0] level_a;
   logic [PINS-1:0] level_b;
   logic req_a;
   logic req_b;
   logic global_irq_enable;
   logic porta_level_edge_select;
   logic portb_edge_select;
   gpc_trig_t mode_a;
   gpc_trig_t mode_b;
   logic [IRQ_W-1:0] irq_set;
   logic [IRQ_W-1:0] irq_clr;

   function automatic logic reg_mapped(input logic [ADDR_W-1:0] addr);
      logic [ADDR_W-1:0] word;
      word = {addr[ADDR_W-1:2], 2'b00};
      reg_mapped = (word == OFS_DATA_A) || (word == OFS_DATA_B) || (word == OFS_DIR_A)
         || (word == OFS_DIR_B) || (word == OFS_OPT_A) || (word == OFS_OPT_B)
         || (word == OFS_IRQ_OPT) || (word == OFS_IRQ_STATUS)
         || (word == OFS_IRQ_CLEAR) || (word == OFS_IRQ_ENABLE);
   endfunction : reg_mapped

   function automatic logic wr_hit(input logic [ADDR_W-1:0] addr,
                                   input logic [ADDR_W-1:0] ofs);
      wr_hit = {addr[ADDR_W-1:2], 2'b00} == ofs;
   endfunction : wr_hit

   assign global_irq_enable = irq_opt[BIT_GLOBAL_EN];
   assign porta_level_edge_select = irq_opt[BIT_LEVEL_EDGE_A];
   assign portb_edge_select = irq_opt[BIT_EDGE_B];

   // Write side: address and data may arrive in either order
   assign wr_fire = aw_held && w_held && !s_axi_bvalid_o;

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         aw_held <= 1'b0;
         aw_addr <= '0;
         s_axi_awready_o <= 1'b1;
      end else if (s_axi_awvalid_i && s_axi_awready_o) begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr_i;
         s_axi_awready_o <= 1'b0;
      end else if (wr_fire) begin
         aw_held <= 1'b0;
      end else if (s_axi_bvalid_o && s_axi_bready_i) begin
         s_axi_awready_o <= 1'b1;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         w_held <= 1'b0;
         w_byte <= 8'h00;
         w_lane0 <= 1'b0;
         s_axi_wready_o <= 1'b1;
      end else if (s_axi_wvalid_i && s_axi_wready_o) begin
         w_held <= 1'b1;
         w_byte <= s_axi_wdata_i[7:0];
         w_lane0 <= s_axi_wstrb_i[0];
         s_axi_wready_o <= 1'b0;
      end else if (wr_fire) begin
         w_held <= 1'b0;
      end else if (s_axi_bvalid_o && s_axi_bready_i) begin
         s_axi_wready_o <= 1'b1;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o <= RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid_o <= 1'b1;
         s_axi_bresp_o <= reg_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready_i) begin
         s_axi_bvalid_o <= 1'b0;
      end
   end

   // Port registers; only byte lane 0 carries bits, upper lanes are ignored
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         pin_data_bits_a <= RST_PORT;
         pin_data_bits_b <= RST_PORT;
         dir_a <= RST_PORT;
         dir_b <= RST_PORT;
         opt_a <= RST_PORT;
         opt_b <= RST_PORT;
      end else if (wr_fire && w_lane0) begin
         // Data writes land in the latch whatever the direction
         if (wr_hit(aw_addr, OFS_DATA_A)) begin
            pin_data_bits_a <= w_byte;
         end
         if (wr_hit(aw_addr, OFS_DATA_B)) begin
            pin_data_bits_b <= w_byte;
         end
         if (wr_hit(aw_addr, OFS_DIR_A)) begin
            dir_a <= w_byte;
         end
         if (wr_hit(aw_addr, OFS_DIR_B)) begin
            dir_b <= w_byte;
         end
         if (wr_hit(aw_addr, OFS_OPT_A)) begin
            opt_a <= w_byte;
         end
         if (wr_hit(aw_addr, OFS_OPT_B)) begin
            opt_b <= w_byte;
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         irq_opt <= RST_IRQ_OPT;
         irq_enable <= RST_IRQ;
      end else if (wr_fire && w_lane0) begin
         if (wr_hit(aw_addr, OFS_IRQ_OPT)) begin
            irq_opt <= w_byte & IRQ_OPT_MASK;
         end
         if (wr_hit(aw_addr, OFS_IRQ_ENABLE)) begin
            irq_enable <= w_byte[IRQ_W-1:0];
         end
      end
   end

   // Read side: one read at a time, data one cycle after the address
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         s_axi_arready_o <= 1'b1;
         s_axi_rvalid_o <= 1'b0;
         s_axi_rresp_o <= RESP_OKAY;
         s_axi_rdata_o <= '0;
      end else if (s_axi_arvalid_i && s_axi_arready_o) begin
         s_axi_arready_o <= 1'b0;
         s_axi_rvalid_o <= 1'b1;
         s_axi_rresp_o <= reg_mapped(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
         s_axi_rdata_o <= '0;
         unique case ({s_axi_araddr_i[ADDR_W-1:2], 2'b00})
            // Input pins read back the pin, output pins the latch
            OFS_DATA_A: s_axi_rdata_o[PINS-1:0] <= (dir_a & pin_data_bits_a)
               | (~dir_a & level_a);
            OFS_DATA_B: s_axi_rdata_o[PINS-1:0] <= (dir_b & pin_data_bits_b)
               | (~dir_b & level_b);
            OFS_DIR_A: s_axi_rdata_o[PINS-1:0] <= dir_a;
            OFS_DIR_B: s_axi_rdata_o[PINS-1:0] <= dir_b;
            OFS_OPT_A: s_axi_rdata_o[PINS-1:0] <= opt_a;
            OFS_OPT_B: s_axi_rdata_o[PINS-1:0] <= opt_b;
            OFS_IRQ_OPT: s_axi_rdata_o[7:0] <= irq_opt;
            OFS_IRQ_STATUS: s_axi_rdata_o[IRQ_W-1:0] <= irq_status;
            OFS_IRQ_ENABLE: s_axi_rdata_o[IRQ_W-1:0] <= irq_enable;
            default: s_axi_rdata_o <= '0;
         endcase
      end else if (s_axi_rvalid_o && s_axi_rready_i) begin
         s_axi_rvalid_o <= 1'b0;
         s_axi_arready_o <= 1'b1;
      end
   end

   // Pin configuration and drive
   gpc_port #(.PIN_N(PINS), .ANALOG_MASK(ANALOG_A)) u_port_a (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .dir_i(dir_a),
      .opt_i(opt_a),
      .dat_i(pin_data_bits_a),
      .pad_i(porta_pad_i),
      .pad_o(porta_pad_o),
      .pad_oe_o(porta_pad_oe_o),
      .pull_en_o(porta_pull_en_o),
      .analog_en_o(porta_analog_en_o),
      .level_o(level_a)
   );

   gpc_port #(.PIN_N(PINS), .ANALOG_MASK(ANALOG_B)) u_port_b (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .dir_i(dir_b),
      .opt_i(opt_b),
      .dat_i(pin_data_bits_b),
      .pad_i(portb_pad_i),
      .pad_o(portb_pad_o),
      .pad_oe_o(portb_pad_oe_o),
      .pull_en_o(portb_pull_en_o),
      .analog_en_o(portb_analog_en_o),
      .level_o(level_b)
   );

   // Trigger selection per port
   assign mode_a = porta_level_edge_select ? TRIG_LOW : TRIG_FALL;
   assign mode_b = portb_edge_select ? TRIG_RISE : TRIG_FALL;

   // Reconfiguring a pin into interrupt mode can latch a request
   gpc_trig #(.PIN_N(PINS)) u_trig_a (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .level_i(level_a),
      .cfg_i(gpc_irq_cfg(dir_a, opt_a, pin_data_bits_a)),
      .mode_i(mode_a),
      .req_o(req_a)
   );

   gpc_trig #(.PIN_N(PINS)) u_trig_b (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .level_i(level_b),
      .cfg_i(gpc_irq_cfg(dir_b, opt_b, pin_data_bits_b)),
      .mode_i(mode_b),
      .req_o(req_b)
   );

   // Sticky status; a new event beats a clear in the same cycle
   assign irq_set = {req_b, req_a} & {IRQ_W{global_irq_enable}};
   assign irq_clr = (wr_fire && w_lane0 && wr_hit(aw_addr, OFS_IRQ_CLEAR)) ?
      w_byte[IRQ_W-1:0] : RST_IRQ;

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         irq_status <= RST_IRQ;
      end else begin
         irq_status <= (irq_status & ~irq_clr) | irq_set;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(irq_status & irq_enable);
      end
   end

   a_reset_state: assert property (@(posedge core_clk_i) disable iff (rst_i)
      $past(rst_i) |-> (dir_a == '0 && opt_a == '0 && pin_data_bits_a == '0
         && dir_b == '0 && opt_b == '0 && pin_data_bits_b == '0 && irq_opt == '0))
      else $error("port registers not cleared by reset");
   a_global_gate: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (!global_irq_enable && irq_status == '0) |=> irq_status == '0)
      else $error("status set while interrupts globally disabled");
   a_set_beats_clear: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (irq_set[IRQ_PORT_A] && irq_clr[IRQ_PORT_A]) |=> irq_status[IRQ_PORT_A])
      else $error("event lost against a simultaneous clear");
   a_read_pin: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == OFS_DATA_A)
      |=> s_axi_rdata_o[PINS-1:0] == (($past(dir_a) & $past(pin_data_bits_a))
         | (~$past(dir_a) & $past(level_a))))
      else $error("data read mixes pin and latch wrongly");
   a_irq_follows: assert property (@(posedge core_clk_i) disable iff (rst_i)
      ((irq_status & irq_enable) != '0) ##1 ((irq_status & irq_enable) != '0) |-> irq_o)
      else $error("interrupt output low with an enabled status bit set");
   a_resp_after_both: assert property (@(posedge core_clk_i) disable iff (rst_i)
      $rose(s_axi_bvalid_o) |-> $past(aw_held && w_held))
      else $error("write response before address and data were both taken");
   a_bvalid_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (s_axi_bvalid_o && !s_axi_bready_i) |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
      else $error("write response dropped before ready");
   a_rvalid_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (s_axi_rvalid_o && !s_axi_rready_i) |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
      else $error("read data dropped or changed before ready");

endmodule : gpc_top

// ==== dv/gpc_pins_model.sv ====
`timescale 1ns/10ps
module gpc_pins_model (
   input wire logic core_clk_i, // System clock
   input wire logic [7:0] pad_i, // Value driven by the port
   input wire logic [7:0] oe_i, // Port drives the pin
   input wire logic [7:0] pull_en_i, // Pull-up on
   input wire logic [7:0] ext_en_i, // Outside circuit drives the pin
   input wire logic [7:0] ext_val_i, // Outside circuit level
   output logic [7:0] level_o // Resolved pin level
);
   logic tog = 1'b0;
   // An undriven pin wanders, so a read of it cannot match by luck
   always_ff @(posedge core_clk_i) tog <= ~tog;
   assign level_o = (oe_i & pad_i) | (~oe_i & ext_en_i & ext_val_i)
      | (~oe_i & ~ext_en_i & (pull_en_i | {8{tog}}));
endmodule : gpc_pins_model

// ==== dv/gpc_top_tb_top.sv ====
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin miscompares++; $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module gpc_top_tb_top;
   import gpc_pkg::*;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0, rdata, rd;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [1:0] bresp, rresp, resp;
   logic [7:0] a_pad, a_oe, a_pull, a_an, a_lvl, b_pad, b_oe, b_pull, b_an, b_lvl;
   logic [7:0] a_ext_en = 8'h00, a_ext_val = 8'h00, b_ext_en = 8'h00, b_ext_val = 8'h00;
   int miscompares = 0;
   int samples_checked = 0;

   always #10 core_clk = ~core_clk;

   gpc_top dut (.core_clk_i(core_clk), .rst_i(rst), .s_axi_awaddr_i(awaddr),
      .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
      .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
      .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
      .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
      .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
      .s_axi_rready_i(rready), .porta_pad_i(a_lvl), .porta_pad_o(a_pad),
      .porta_pad_oe_o(a_oe), .porta_pull_en_o(a_pull), .porta_analog_en_o(a_an),
      .portb_pad_i(b_lvl), .portb_pad_o(b_pad), .portb_pad_oe_o(b_oe),
      .portb_pull_en_o(b_pull), .portb_analog_en_o(b_an), .irq_o(irq));
   gpc_pins_model pin_a (.core_clk_i(core_clk), .pad_i(a_pad), .oe_i(a_oe),
      .pull_en_i(a_pull), .ext_en_i(a_ext_en), .ext_val_i(a_ext_val), .level_o(a_lvl));
   gpc_pins_model pin_b (.core_clk_i(core_clk), .pad_i(b_pad), .oe_i(b_oe),
      .pull_en_i(b_pull), .ext_en_i(b_ext_en), .ext_val_i(b_ext_val), .level_o(b_lvl));

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid && n < 50);
      resp = bresp;
      bready <= 1'b0;
      if (n >= 50) miscompares++;
   endtask : wr

   task automatic rdr(input logic [7:0] a);
      int n;
      n = 0;
      @(posedge core_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
         if (arready) arvalid <= 1'b0;
      end while (!rvalid && n < 50);
      rd = rdata;
      resp = rresp;
      rready <= 1'b0;
      if (n >= 50) miscompares++;
   endtask : rdr

   task automatic t_reset;
      `CHK("a_oe", 8'h00, a_oe)
      `CHK("b_pull", 8'hff, b_pull)
      `CHK("b_an", 8'h00, b_an)
      rdr(OFS_DIR_B);
      `CHK("dir_b", 32'h0, rd)
      rdr(OFS_OPT_A);
      `CHK("opt_a", 32'h0, rd)
      rdr(OFS_DATA_A);
      `CHK("data_a", 32'hff, rd)
   endtask : t_reset

   task automatic t_modes;
      b_ext_en <= 8'h0f;
      b_ext_val <= 8'h05;
      // Data last, so only pin 3 ever turns analog
      wr(OFS_DIR_B, 8'hf0);
      wr(OFS_OPT_B, 8'hcc);
      wr(OFS_DATA_B, 8'haa);
      repeat (4) @(posedge core_clk);
      `CHK("b_pull", 8'h05, b_pull)
      `CHK("b_an", 8'h08, b_an)
      `CHK("b_oe", 8'hd0, b_oe)
      `CHK("b_pad", 8'h80, b_pad & b_oe)
      rdr(OFS_DATA_B);
      `CHK("data_b", 32'ha5, rd)
      wr(OFS_DATA_B, 8'h00);
      repeat (2) @(posedge core_clk);
      `CHK("b_pull", 8'h0f, b_pull)
      `CHK("b_oe", 8'hf0, b_oe)
   endtask : t_modes

   task automatic t_irq_a;
      a_ext_en <= 8'h06;
      a_ext_val <= 8'h06;
      wr(OFS_OPT_A, 8'h06);
      wr(OFS_IRQ_ENABLE, 8'h03);
      wr(OFS_IRQ_OPT, 8'h10);
      a_ext_val <= 8'h04;
      repeat (8) @(posedge core_clk);
      `CHK("irq", 1'b1, irq)
      wr(OFS_IRQ_CLEAR, 8'h01);
      rdr(OFS_IRQ_STATUS);
      `CHK("status", 32'h0, rd)
      wr(OFS_IRQ_OPT, 8'h50);
      wr(OFS_IRQ_CLEAR, 8'h01);
      rdr(OFS_IRQ_STATUS);
      `CHK("status", 32'h1, rd)
      wr(OFS_IRQ_OPT, 8'h40);
      wr(OFS_IRQ_CLEAR, 8'h01);
      rdr(OFS_IRQ_STATUS);
      `CHK("status", 32'h0, rd)
      wr(OFS_IRQ_ENABLE, 8'h02);
      wr(OFS_IRQ_OPT, 8'h50);
      repeat (4) @(posedge core_clk);
      `CHK("irq", 1'b0, irq)
      a_ext_val <= 8'h06;
      wr(OFS_IRQ_OPT, 8'h10);
      wr(OFS_IRQ_CLEAR, 8'h03);
      wr(OFS_IRQ_ENABLE, 8'h03);
      a_ext_val <= 8'h02;
      repeat (8) @(posedge core_clk);
      `CHK("irq", 1'b1, irq)
   endtask : t_irq_a

   task automatic t_irq_b;
      wr(OFS_IRQ_OPT, 8'h30);
      wr(OFS_IRQ_CLEAR, 8'h03);
      b_ext_val <= 8'h0d;
      repeat (8) @(posedge core_clk);
      rdr(OFS_IRQ_STATUS);
      `CHK("status", 32'h2, rd)
      wr(OFS_IRQ_OPT, 8'h10);
      wr(OFS_IRQ_CLEAR, 8'h03);
      b_ext_val <= 8'h05;
      repeat (8) @(posedge core_clk);
      rdr(OFS_IRQ_STATUS);
      `CHK("status", 32'h2, rd)
   endtask : t_irq_b

   task automatic t_bus;
      wr(8'h28, 8'h01);
      `CHK("bresp", RESP_SLVERR, resp)
      rdr(8'h30);
      `CHK("rresp", RESP_SLVERR, resp)
      wr(OFS_DIR_A, 8'h5a);
      rdr(OFS_DIR_A);
      `CHK("dir_a", 32'h5a, rd)
      // Pin 2 asks for analog, but port A has no converter inputs
      wr(OFS_DATA_A, 8'h06);
      repeat (2) @(posedge core_clk);
      `CHK("a_an", 8'h00, a_an)
      `CHK("a_pad", 8'h02, a_pad & a_oe)
      `CHK("a_oe", 8'h5a, a_oe)
      `CHK("a_pull", 8'ha1, a_pull)
      rdr(OFS_DATA_A);
      `CHK("data_a", 32'ha3, rd)
      wr(OFS_IRQ_OPT, 8'hff);
      rdr(OFS_IRQ_OPT);
      `CHK("irq_opt", 32'h70, rd)
   endtask : t_bus

   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : give_verdict

   initial begin
      repeat (8) @(posedge core_clk);
      rst <= 1'b0;
      t_reset();
      t_modes();
      t_irq_a();
      t_irq_b();
      t_bus();
      give_verdict();
   end

   initial begin
      repeat (5000) @(posedge core_clk);
      miscompares++;
      give_verdict();
   end
endmodule : gpc_top_tb_top
